//--- pkg/fpe_pkg.sv
/*
  Package for the flash program/erase controller: memory map, control bits, timing, command types.
  Assumes a 20 MHz clock and a device whose flash and control register sit on a plain byte bus.
*/
package fpe_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'hFE08;
  localparam logic [15:0] BOUNDARY_ADDR = 16'hFF7E;
  localparam logic [15:0] TRIM_HI_ADDR = 16'hFF80;
  localparam logic [15:0] TRIM_LO_ADDR = 16'hFF81;
  localparam logic [15:0] FLASH_BASE = 16'hC000;
  localparam logic [15:0] WATCHDOG_ADDR = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BOUNDARY_OPEN = 8'hFF;
  localparam logic [7:0] BOUNDARY_ALL = 8'h00;
  localparam logic [7:0] BOUNDARY_VECT = 8'hFE;
  localparam int ROW_BYTES = 32;
  localparam int ROW_LSB = 5;
  // Control register bit positions
  localparam int BIT_PGM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam int CLK_MHZ = 20;
  localparam int SETUP_US = 10;
  localparam int WHOLE_ERASE_US = 4000;
  localparam int LONG_HOLD_US = 100;
  localparam int HOLD_US = 5;
  localparam int PGM_SETUP_US = 5;
  localparam int BYTE_PGM_US = 30;
  localparam int RECOVERY_US = 1;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int ERASE_CYC = WHOLE_ERASE_US * CLK_MHZ;
  localparam int LONG_HOLD_CYC = LONG_HOLD_US * CLK_MHZ;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int PGM_SETUP_CYC = PGM_SETUP_US * CLK_MHZ;
  localparam int BYTE_PGM_CYC = BYTE_PGM_US * CLK_MHZ;
  localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  typedef enum logic [1:0] {FPE_CMD_ERASE, FPE_CMD_PROGRAM, FPE_CMD_READ} fpe_op_t;
  typedef struct packed {
    fpe_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } fpe_cmd_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fpe_bus_t;
  typedef enum logic [1:0] {FPE_OK, FPE_PROTECTED, FPE_NOT_ERASED} fpe_status_t;
  // start address of the protected range
  function automatic logic [15:0] fpe_protect_start(input logic [7:0] b);
    fpe_protect_start = {2'b11, b, 6'h00};
  endfunction : fpe_protect_start
endpackage : fpe_pkg

//--- rtl/fpe_timer.sv
/*
  Down counter for the controller's timed waits.
  Assumes load and start from the same clock domain.
*/
module fpe_timer #(
  parameter int WIDTH = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;
  if (WIDTH < 2)
  begin : g_width_chk
    $error("fpe_timer width too small");
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= '0;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end
  assign done = (cnt_r == '0) && !load;
endmodule : fpe_timer

//--- rtl/fpe_ctrl.sv
/*
  Controller that sequences whole-array erase and single-byte programming within a row of the device flash.
  Assumes a device byte bus with one-cycle reads whose data returns on the next clock;
  the controller itself runs from outside the flash array.
*/
module fpe_ctrl #(
  parameter int ERASE_CYCLES = fpe_pkg::ERASE_CYC,
  parameter int TW = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fpe_pkg::fpe_cmd_t cmd,
  input wire logic monitor_insecure,
  output logic cmd_ready,
  output logic done,
  output fpe_pkg::fpe_status_t status,
  output logic [7:0] rdata,
  output fpe_pkg::fpe_bus_t bus,
  input wire logic [7:0] bus_rdata
);
  import fpe_pkg::*;
  if (ERASE_CYCLES >= (1 << TW) || ERASE_CYCLES < 1 || LONG_HOLD_CYC >= (1 << TW) ||
      BYTE_PGM_CYC >= (1 << TW))
  begin : g_width_chk
    $error("timer width too small");
  end

  typedef enum {
    S_IDLE, S_RDBND, S_BND_GET, S_CHKBND, S_SEL, S_RDBND2, S_ARM, S_SETUP, S_HV, S_HOLD,
    S_BYTE_RD, S_BYTE_CHK, S_BYTE_WR, S_BYTE_WAIT, S_DESEL, S_HVHOLD, S_HVOFF,
    S_RECOVER, S_READ, S_READ_GET, S_DONE
  } fpe_state_t;

  fpe_state_t state_r;
  fpe_cmd_t cmd_r;
  logic [7:0] ctrl_r;
  logic [7:0] bnd_r;
  logic [4:0] idx_r;
  logic ld;
  logic [TW-1:0] ld_cnt;
  logic tdone;

  fpe_timer #(.WIDTH(TW)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(ld),
    .count(ld_cnt),
    .done(tdone)
  );

  function automatic logic [TW-1:0] cyc(input int n);
    cyc = TW'(n);
  endfunction : cyc

  function automatic logic [15:0] row_addr(input logic [15:0] a, input logic [4:0] i);
    row_addr = {a[15:ROW_LSB], i};
  endfunction : row_addr

  always_comb
  begin
    ld = 1'b0;
    ld_cnt = '0;
    unique case (state_r)
      S_ARM:
      begin
        ld = 1'b1;
        ld_cnt = cyc(SETUP_CYC);
      end
      S_HV:
      begin
        ld = 1'b1;
        ld_cnt = (cmd_r.op == FPE_CMD_ERASE) ? cyc(ERASE_CYCLES) : cyc(PGM_SETUP_CYC);
      end
      S_BYTE_WR:
      begin
        ld = 1'b1;
        ld_cnt = cyc(BYTE_PGM_CYC);
      end
      S_DESEL:
      begin
        ld = 1'b1;
        ld_cnt = (cmd_r.op == FPE_CMD_ERASE) ? cyc(LONG_HOLD_CYC) : cyc(HOLD_CYC);
      end
      S_HVOFF:
      begin
        ld = 1'b1;
        ld_cnt = cyc(RECOVERY_CYC);
      end
      default:
      begin
        ld = 1'b0;
        ld_cnt = '0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= S_IDLE;
      cmd_r <= '0;
      ctrl_r <= 8'h00;
      bnd_r <= BOUNDARY_OPEN;
      idx_r <= '0;
      status <= FPE_OK;
      done <= 1'b0;
      cmd_ready <= 1'b1;
      rdata <= 8'h00;
      bus <= '0;
    end
    else
    begin
      bus <= '0;
      done <= 1'b0;
      unique case (state_r)
        S_IDLE:
          if (cmd_valid)
          begin
            cmd_r <= cmd;
            cmd_ready <= 1'b0;
            // Byte index inside the row, so the read-back targets the commanded byte
            idx_r <= cmd.addr[ROW_LSB-1:0];
            bus.rd <= 1'b1;
            bus.addr <= (cmd.op == FPE_CMD_READ) ? cmd.addr : BOUNDARY_ADDR;
            state_r <= (cmd.op == FPE_CMD_READ) ? S_READ_GET : S_RDBND;
          end
        // Device read data stands only in the cycle after the strobe
        S_RDBND:
          state_r <= S_BND_GET;
        S_BND_GET:
        begin
          bnd_r <= bus_rdata;
          state_r <= S_CHKBND;
        end
        S_CHKBND:
          // Refuse early rather than leave selects armed against a locked array
          if (cmd_r.op == FPE_CMD_ERASE && bnd_r != BOUNDARY_OPEN)
          begin
            status <= FPE_PROTECTED;
            state_r <= S_DONE;
          end
          else if (cmd_r.op == FPE_CMD_PROGRAM && (bnd_r == BOUNDARY_ALL ||
                   cmd_r.addr >= fpe_protect_start(bnd_r) && bnd_r != BOUNDARY_OPEN))
          begin
            status <= FPE_PROTECTED;
            state_r <= S_DONE;
          end
          else
          begin
            ctrl_r <= (cmd_r.op == FPE_CMD_ERASE) ?
                      (8'h00 | (8'h01 << BIT_ERASE) | (8'h01 << BIT_MASS)) :
                      (8'h00 | (8'h01 << BIT_PGM));
            bus.wr <= 1'b1;
            bus.addr <= CTRL_ADDR;
            bus.wdata <= (cmd_r.op == FPE_CMD_ERASE) ?
                         ((8'h01 << BIT_ERASE) | (8'h01 << BIT_MASS)) : (8'h01 << BIT_PGM);
            state_r <= S_SEL;
          end
        S_SEL:
        begin
          bus.rd <= 1'b1;
          bus.addr <= BOUNDARY_ADDR;
          state_r <= S_RDBND2;
        end
        S_RDBND2:
        begin
          bus.wr <= 1'b1;
          bus.addr <= (cmd_r.op == FPE_CMD_ERASE) ?
                      (monitor_insecure ? BOUNDARY_ADDR : FLASH_BASE) :
                      row_addr(cmd_r.addr, 5'h00);
          bus.wdata <= cmd_r.data;
          state_r <= S_ARM;
        end
        S_ARM:
          state_r <= S_SETUP;
        S_SETUP:
          if (tdone)
          begin
            ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] <= 1'b1;
            bus.wr <= 1'b1;
            bus.addr <= CTRL_ADDR;
            bus.wdata <= ctrl_r | (8'h01 << BIT_HIGH_VOLTAGE_ENABLE);
            state_r <= S_HV;
          end
        S_HV:
          state_r <= S_HOLD;
        S_HOLD:
          if (tdone)
          begin
            if (cmd_r.op == FPE_CMD_ERASE)
            begin
              state_r <= S_DESEL;
              ctrl_r <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
              bus.wr <= 1'b1;
              bus.addr <= CTRL_ADDR;
              bus.wdata <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
            end
            else
            begin
              bus.rd <= 1'b1;
              bus.addr <= row_addr(cmd_r.addr, idx_r);
              state_r <= S_BYTE_RD;
            end
          end
        S_BYTE_RD:
          state_r <= S_BYTE_CHK;
        S_BYTE_CHK:
          // Only the commanded byte is written; others in the row stay erased
          if (row_addr(cmd_r.addr, idx_r) == cmd_r.addr && bus_rdata == ERASED_BYTE &&
              cmd_r.addr != WATCHDOG_ADDR)
          begin
            bus.wr <= 1'b1;
            bus.addr <= cmd_r.addr;
            bus.wdata <= cmd_r.data;
            state_r <= S_BYTE_WR;
          end
          else
          begin
            if (row_addr(cmd_r.addr, idx_r) == cmd_r.addr)
              status <= FPE_NOT_ERASED;
            state_r <= S_DESEL;
            ctrl_r <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
            bus.wr <= 1'b1;
            bus.addr <= CTRL_ADDR;
            bus.wdata <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
          end
        S_BYTE_WR:
          state_r <= S_BYTE_WAIT;
        S_BYTE_WAIT:
          if (tdone)
          begin
            // Drop select immediately so the gap stays inside the program limit
            ctrl_r <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
            bus.wr <= 1'b1;
            bus.addr <= CTRL_ADDR;
            bus.wdata <= 8'h01 << BIT_HIGH_VOLTAGE_ENABLE;
            state_r <= S_DESEL;
          end
        S_DESEL:
          state_r <= S_HVHOLD;
        S_HVHOLD:
          if (tdone)
          begin
            ctrl_r <= 8'h00;
            bus.wr <= 1'b1;
            bus.addr <= CTRL_ADDR;
            bus.wdata <= 8'h00;
            state_r <= S_HVOFF;
          end
        S_HVOFF:
          state_r <= S_RECOVER;
        S_RECOVER:
          if (tdone)
            state_r <= S_DONE;
        S_READ_GET:
          state_r <= S_READ;
        S_READ:
        begin
          rdata <= bus_rdata;
          state_r <= S_DONE;
        end
        S_DONE:
        begin
          done <= 1'b1;
          cmd_ready <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
      if (state_r == S_IDLE && cmd_valid)
        status <= FPE_OK;
    end
  end
endmodule : fpe_ctrl

//--- tb/fpe_ctrl_props.sv
/*
  Checker for fpe_ctrl: ordering, timing and refusal relations on the device byte bus.
  Assumes it is bound to fpe_ctrl and sees only its ports.
*/
module fpe_ctrl_props #(
  parameter int ERASE_CYCLES = fpe_pkg::ERASE_CYC,
  parameter int TW = 17
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire fpe_pkg::fpe_cmd_t cmd,
  input wire logic monitor_insecure,
  input wire logic cmd_ready,
  input wire logic done,
  input wire fpe_pkg::fpe_status_t status,
  input wire logic [7:0] rdata,
  input wire fpe_pkg::fpe_bus_t bus,
  input wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpe_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  fpe_cmd_t cmd_q;
  logic [19:0] gap_r;
  logic [3:0] last_r;
  logic [2:0] sel_r;
  wire logic ctl_wr = bus.wr && bus.addr == CTRL_ADDR;
  wire logic bnd_rd = bus.rd && bus.addr == BOUNDARY_ADDR;
  always_ff @(posedge clk)
    if (reset) cmd_q <= '0;
    else if (cmd_valid && cmd_ready) cmd_q <= cmd;
  // Write gap counter saturates so long erase waits never wrap
  always_ff @(posedge clk)
    if (reset) gap_r <= '0;
    else if (bus.wr) gap_r <= 20'h00001;
    else if (gap_r != 20'hFFFFF) gap_r <= gap_r + 20'h00001;
  always_ff @(posedge clk)
    if (reset) last_r <= '0;
    else if (ctl_wr) last_r <= bus.wdata[3:0];
  always_ff @(posedge clk)
    if (reset) sel_r <= '0;
    else if (ctl_wr && bus.wdata[2:0] != 3'h0) sel_r <= bus.wdata[2:0];
  sequence s_select;
    ctl_wr && bus.wdata[BIT_ERASE] && !bus.wdata[BIT_HIGH_VOLTAGE_ENABLE];
  endsequence
  sequence s_insecure_read;
    monitor_insecure ##0 s_select ##[1:8] bnd_rd;
  endsequence
  AST_BOUNDARY_FIRST: assert property (cmd_valid && cmd_ready && cmd.op != FPE_CMD_READ
    |-> ##[1:2] bnd_rd) else $error("boundary byte not read first");
  AST_ARM_INSECURE: assert property (s_insecure_read
    |-> ##[1:8] (bus.wr && bus.addr == BOUNDARY_ADDR)) else $error("arm write misplaced");
  AST_NO_DUAL: assert property (ctl_wr
    |-> !(bus.wdata[BIT_PGM] && bus.wdata[BIT_ERASE])) else $error("both selects written");
  AST_NO_WATCHDOG: assert property (bus.wr |-> bus.addr != WATCHDOG_ADDR)
    else $error("watchdog address written");
  AST_SETUP_DELAY: assert property (ctl_wr && bus.wdata[BIT_HIGH_VOLTAGE_ENABLE] && bus.wdata[1:0] != 2'h0
    |-> gap_r >= SETUP_CYC - 1) else $error("high voltage too early");
  AST_ERASE_HOLD: assert property (ctl_wr && bus.wdata[3:0] == 4'h8 && last_r == 4'hE
    |-> gap_r >= ERASE_CYCLES - 1) else $error("erase hold too short");
  AST_HV_DROP: assert property (ctl_wr && bus.wdata[3:0] == 4'h0 && last_r == 4'h8
    |-> gap_r >= (sel_r[BIT_ERASE] ? LONG_HOLD_CYC : HOLD_CYC) - 1)
    else $error("high voltage dropped too early");
  AST_ERASE_REFUSED: assert property (bnd_rd ##1
    (cmd_q.op == FPE_CMD_ERASE && bus_rdata != BOUNDARY_OPEN) |-> (!bus.wr) [*8])
    else $error("erase not refused");
  AST_PROG_REFUSED: assert property (bnd_rd ##1 (cmd_q.op == FPE_CMD_PROGRAM
    && (bus_rdata == BOUNDARY_ALL || (bus_rdata != BOUNDARY_OPEN
    && cmd_q.addr >= {2'b11, bus_rdata, 6'h00}))) |-> (!bus.wr) [*8])
    else $error("program not refused");
  AST_NOT_ERASED: assert property (bus.rd && cmd_q.op == FPE_CMD_PROGRAM
    && bus.addr == cmd_q.addr && bus.addr != BOUNDARY_ADDR ##1 bus_rdata != ERASED_BYTE
    |-> (!(bus.wr && bus.addr == cmd_q.addr)) [*8]) else $error("programmed a used byte");
endmodule : fpe_ctrl_props

bind fpe_ctrl fpe_ctrl_props #(.ERASE_CYCLES(ERASE_CYCLES), .TW(TW)) props_u (.clk(clk),
  .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .monitor_insecure(monitor_insecure),
  .cmd_ready(cmd_ready), .done(done), .status(status), .rdata(rdata), .bus(bus),
  .bus_rdata(bus_rdata));

//--- tb/fpe_flash_model.sv
/*
  Behavioural model of the device flash, control register and boundary byte.
  Assumes registered bus strobes; read data stands one cycle, then is scrambled.
*/
module fpe_flash_model (
  input wire logic clk,
  input wire logic reset,
  input wire fpe_pkg::fpe_bus_t bus,
  output logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import fpe_pkg::*;
  logic [7:0] mem [16'hC000:16'hFFFF];
  logic [3:0] ctrl_r;
  logic seen_r;
  logic armed_r;
  logic [15:0] arm_r;
  logic [7:0] bnd;
  logic ok;
  logic [7:0] osc_trim_r;
  assign bnd = mem[BOUNDARY_ADDR];
  // No test voltage is modelled, so the boundary byte can never be programmed
  assign ok = ctrl_r[1:0] != 2'h0 && armed_r && (ctrl_r[BIT_ERASE] ? bnd == BOUNDARY_OPEN
    : !(bnd == BOUNDARY_ALL || arm_r == BOUNDARY_ADDR
    || (bnd != BOUNDARY_OPEN && arm_r >= {2'b11, bnd, 6'h00})));
  initial
  begin
    for (int a = 16'hC000; a <= 16'hFFFF; a++) mem[a] = ERASED_BYTE;
    mem[TRIM_HI_ADDR] = 8'h5C;
    mem[TRIM_LO_ADDR] = 8'h3A;
  end
  // Monitor start-up copies the high-supply trim unless that store is erased
  always @(posedge clk)
    if (reset && mem[TRIM_HI_ADDR] != ERASED_BYTE) osc_trim_r <= mem[TRIM_HI_ADDR];
  always @(posedge clk)
    if (reset) bus_rdata <= 8'h00;
    else if (bus.rd) bus_rdata <= bus.addr == CTRL_ADDR ? {4'h0, ctrl_r}
      : (bus.addr >= FLASH_BASE ? mem[bus.addr] : 8'h00);
    else bus_rdata <= ~bus_rdata;
  always @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_r <= 4'h0;
      armed_r <= 1'b0;
      seen_r <= 1'b0;
    end
    else if (bus.rd && bus.addr == BOUNDARY_ADDR && ctrl_r[1:0] != 2'h0) seen_r <= 1'b1;
    else if (bus.wr && bus.addr == CTRL_ADDR && !(bus.wdata[BIT_PGM] && bus.wdata[BIT_ERASE]))
    begin
      ctrl_r <= bus.wdata[3:0];
      if (bus.wdata[BIT_HIGH_VOLTAGE_ENABLE] && !ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] && !ok) ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] <= 1'b0;
      if (bus.wdata[BIT_HIGH_VOLTAGE_ENABLE] && !ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] && ok && ctrl_r[BIT_ERASE] && ctrl_r[BIT_MASS])
        for (int a = 16'hC000; a <= 16'hFFFF; a++) mem[a] <= ERASED_BYTE;
      if (bus.wdata[1:0] == 2'h0) seen_r <= 1'b0;
      if (bus.wdata[1:0] == 2'h0) armed_r <= 1'b0;
    end
    else if (bus.wr && bus.addr >= FLASH_BASE && ctrl_r[1:0] != 2'h0 && !ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] && seen_r)
    begin
      armed_r <= 1'b1;
      arm_r <= bus.addr;
    end
    else if (bus.wr && ctrl_r[BIT_PGM] && ctrl_r[BIT_HIGH_VOLTAGE_ENABLE] && bus.addr[15:5] == arm_r[15:5]
      && bus.addr != BOUNDARY_ADDR) mem[bus.addr] <= mem[bus.addr] & bus.wdata;
  end
endmodule : fpe_flash_model

//--- tb/testbench.sv
/*
  Self-checking bench for fpe_ctrl driving the behavioural flash model.
  Assumes a 50 ns clock; the whole-array erase time is shortened by parameter.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fpe_pkg::*;
  logic clk, reset, cmd_valid, monitor_insecure, cmd_ready, done;
  fpe_cmd_t cmd;
  fpe_status_t status;
  fpe_bus_t bus;
  logic [7:0] rdata, bus_rdata;
  int err_count, samples_checked;
  fpe_ctrl #(.ERASE_CYCLES(50), .TW(17)) dut_u (.clk(clk), .reset(reset),
    .cmd_valid(cmd_valid), .cmd(cmd), .monitor_insecure(monitor_insecure),
    .cmd_ready(cmd_ready), .done(done), .status(status), .rdata(rdata), .bus(bus),
    .bus_rdata(bus_rdata));
  fpe_flash_model model_u (.clk(clk), .reset(reset), .bus(bus), .bus_rdata(bus_rdata));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input fpe_op_t op, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    @(negedge clk);
    cmd_valid = 1'b0;
    check({15'h0000, cmd_ready}, 16'h0000);
    n = 0;
    while (done !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    check(16'(n < 5000), 16'h0001);
    check({15'h0000, cmd_ready}, 16'h0001);
  endtask : run
  task automatic expect_byte(input logic [15:0] a, input logic [7:0] v);
    run(FPE_CMD_READ, a, 8'h00);
    check({8'h00, rdata}, {8'h00, v});
  endtask : expect_byte
  task automatic t_trims();
    expect_byte(TRIM_HI_ADDR, 8'h5C);
    expect_byte(TRIM_LO_ADDR, 8'h3A);
    check({8'h00, model_u.osc_trim_r}, 16'h005C);
  endtask : t_trims
  task automatic t_program();
    run(FPE_CMD_PROGRAM, 16'hC025, 8'h5A);
    check(16'(status), 16'(FPE_OK));
    expect_byte(16'hC025, 8'h5A);
    expect_byte(16'hC024, 8'hFF);
    run(FPE_CMD_PROGRAM, 16'hC025, 8'h00);
    check(16'(status), 16'(FPE_NOT_ERASED));
    expect_byte(16'hC025, 8'h5A);
  endtask : t_program
  task automatic t_protect();
    // Boundary 80 puts the protect start at E000
    model_u.mem[BOUNDARY_ADDR] = 8'h80;
    run(FPE_CMD_PROGRAM, 16'hDFC0, 8'h11);
    check(16'(status), 16'(FPE_OK));
    run(FPE_CMD_PROGRAM, 16'hE000, 8'h11);
    check(16'(status), 16'(FPE_PROTECTED));
    expect_byte(16'hE000, 8'hFF);
    run(FPE_CMD_ERASE, 16'hC000, 8'h00);
    check(16'(status), 16'(FPE_PROTECTED));
    expect_byte(16'hDFC0, 8'h11);
    model_u.mem[BOUNDARY_ADDR] = 8'h00;
    run(FPE_CMD_PROGRAM, 16'hC000, 8'h11);
    check(16'(status), 16'(FPE_PROTECTED));
    model_u.mem[BOUNDARY_ADDR] = 8'hFE;
    run(FPE_CMD_PROGRAM, 16'hFF40, 8'h22);
    check(16'(status), 16'(FPE_OK));
    run(FPE_CMD_PROGRAM, 16'hFF80, 8'h22);
    check(16'(status), 16'(FPE_PROTECTED));
    model_u.mem[BOUNDARY_ADDR] = 8'hFF;
  endtask : t_protect
  task automatic t_erase();
    for (int m = 0; m < 2; m++)
    begin
      @(negedge clk);
      monitor_insecure = 1'(m);
      run(FPE_CMD_ERASE, 16'hC000, 8'h00);
      check(16'(status), 16'(FPE_OK));
      expect_byte(16'hDFC0, 8'hFF);
      expect_byte(TRIM_HI_ADDR, 8'hFF);
      expect_byte(TRIM_LO_ADDR, 8'hFF);
    end
  endtask : t_erase
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Whole run is about 8200 cycles; nearly five times that covers slow answers
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    monitor_insecure = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    t_trims();
    t_program();
    t_protect();
    t_erase();
    tally_and_finish();
  end
endmodule : testbench
